// ==== rtl/ppmr_pkg.sv ====
// Package for the power management and PHY output control register bank
package ppmr_pkg;
  localparam logic [7:0] PPMR_OFF_CTRL_STATUS = 8'h48;
  localparam logic [7:0] PPMR_OFF_EXTENSION = 8'h4a;
  localparam logic [7:0] PPMR_OFF_PHY_CTRL = 8'hec;
  localparam logic [7:0] PPMR_EEPROM_PHY_BYTE = 8'h16;
  localparam int PPMR_BIT_WAKE_FLAG = 15;
  localparam int PPMR_BIT_WAKE_GATE = 8;
  localparam int PPMR_BIT_ROUTE = 7;
  localparam int PPMR_BIT_STD_REV = 3;
  localparam logic [15:0] PPMR_RST_CTRL_STATUS = 16'h0000;
  localparam logic [15:0] PPMR_RST_EXTENSION = 16'h0000;
  localparam logic [31:0] PPMR_RST_PHY_CTRL = 32'h00000008;

  typedef enum logic [1:0] {PPMR_D0, PPMR_D1, PPMR_D2, PPMR_D3} ppmr_level_e;

  // One configuration access; byteEn follows the bus byte enables, active high
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } ppmr_cfg_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ppmr_eeprom_s;
endpackage

// ==== rtl/ppmr_regs.sv ====
// Power management control/status, extension and PHY control registers
// Behaviour
// - Wake flag bit 15 sets on every wake event, whatever the gate.
// - Writing 1 clears flag and releases wake output; writing 0 does nothing.
// - Meter scale bits 14-13 and select bits 12-9 read zero.
// - Wake output sets on a wake event only while gate bit 8 is one, then holds until flag bit 15 is written 1.
// - Gate resets to 0 unless unpowered wake supported; then sticky, software clears.
// - Power level bits 1-0 select D0, D1, D2, D3.
// - Control/status keeps flag and level through the D3hot-to-D0 internal reset; the gate is kept only when sticky.
// - Flagged bits clear only on global hard reset.
// - Control/status bits 7-2 read zero.
// - Extension register is read-only zero.
// - Route bit 7 set drives cable activity to its output pin.
// - EEPROM byte 16h bit 7 loads the route bit.
// - PHY control bit 3 defaults to one.
// - PHY control bits 31-8 read zero.
// - Unpowered wake support comes from capability bit 15.
`timescale 1ns/100ps
module ppmr_regs
  import ppmr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic softResetN,
  input wire ppmr_cfg_s cfg,
  output logic [31:0] cfgRdata,
  input wire ppmr_eeprom_s eeprom,
  input wire logic wakeEvent,
  input wire logic wakeFromUnpoweredCap,
  input wire logic cableActivityIn,
  output logic wakeOutN,
  output logic [1:0] devicePowerLevel,
  output logic cableActivityOut
);
  logic wakeFlag_reg, wakeGate_reg, route_reg, wakeOut_reg, cableOut_reg;
  logic wakeOutN_reg;
  logic [1:0] level_reg;
  logic [31:0] rdata_reg;
  logic cableSync1_reg, cableSync2_reg;
  logic wakeSync1_reg, wakeSync2_reg, capSync1_reg, capSync2_reg;
  logic gateSticky;

  // Register offset 48h sits in lanes 1:0, 4Ah in lanes 3:2 of the same dword
  wire hitPm = cfg.addr[7:2] == PPMR_OFF_CTRL_STATUS[7:2];
  wire hitPhy = cfg.addr[7:2] == PPMR_OFF_PHY_CTRL[7:2];
  wire wrPmLo = cfg.write && hitPm && cfg.byteEn[0];
  wire wrPmHi = cfg.write && hitPm && cfg.byteEn[1];
  wire wrPhy = cfg.write && hitPhy && cfg.byteEn[0];
  wire clearFlag = wrPmHi && cfg.wdata[PPMR_BIT_WAKE_FLAG];
  wire eepromPhy = eeprom.valid; // Loader only presents byte 16h
  wire [15:0] pmView = {wakeFlag_reg, 6'h00, wakeGate_reg, 6'h00, level_reg};
  wire [31:0] pmDword = {PPMR_RST_EXTENSION, pmView};
  wire [31:0] phyView = {24'h000000, route_reg, 3'h0, 1'b1, 3'h0};
  wire [31:0] rdNext = !cfg.read ? rdata_reg : hitPm ? pmDword : hitPhy ? phyView : 32'h0;
  wire wakeNext = (wakeOut_reg && !clearFlag) || (wakeSync2_reg && wakeGate_reg);

  assign gateSticky = capSync2_reg;

  // Plain-reset domain: read data and cable output; the synchronisers have no reset
  always_ff @(posedge mclk) begin
    cableSync1_reg <= cableActivityIn;
    cableSync2_reg <= cableSync1_reg;
    wakeSync1_reg <= wakeEvent;
    wakeSync2_reg <= wakeSync1_reg;
    capSync1_reg <= wakeFromUnpoweredCap;
    capSync2_reg <= capSync1_reg;
    if (!rstn) begin
      rdata_reg <= 32'h0;
      cableOut_reg <= 1'b0;
    end else begin
      rdata_reg <= rdNext;
      cableOut_reg <= route_reg && cableSync2_reg;
    end
  end

  // Held only by global hard reset; the D3hot-to-D0 reset is ignored here
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wakeFlag_reg <= PPMR_RST_CTRL_STATUS[PPMR_BIT_WAKE_FLAG];
      level_reg <= PPMR_RST_CTRL_STATUS[1:0];
      route_reg <= PPMR_RST_PHY_CTRL[PPMR_BIT_ROUTE];
      wakeOut_reg <= 1'b0;
      wakeOutN_reg <= 1'b1;
    end else begin
      wakeFlag_reg <= wakeSync2_reg || (wakeFlag_reg && !clearFlag);
      wakeOut_reg <= wakeNext;
      // Inverted copy kept in its own flop so the pin has no gate after it
      wakeOutN_reg <= !wakeNext;
      if (wrPmLo) level_reg <= cfg.wdata[1:0];
      if (eepromPhy) route_reg <= eeprom.data[PPMR_BIT_ROUTE];
      else if (wrPhy) route_reg <= cfg.wdata[PPMR_BIT_ROUTE];
    end
  end

  // Gate survives the function reset only when unpowered wake is supported
  always_ff @(posedge mclk) begin
    if (!rstn || (!softResetN && !gateSticky)) begin
      wakeGate_reg <= PPMR_RST_CTRL_STATUS[PPMR_BIT_WAKE_GATE];
    end else if (wrPmHi) begin
      wakeGate_reg <= cfg.wdata[PPMR_BIT_WAKE_GATE];
    end
  end

  assign cfgRdata = rdata_reg;
  assign wakeOutN = wakeOutN_reg;
  assign devicePowerLevel = level_reg;
  assign cableActivityOut = cableOut_reg;

  property flagSetsP;
    @(posedge mclk) disable iff (!rstn) wakeSync2_reg |=> wakeFlag_reg;
  endproperty
  wake_flag_set_a: assert property (flagSetsP) else $error("wake flag missed event");
  wake_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
    clearFlag && !wakeSync2_reg |=> !wakeFlag_reg && !wakeOut_reg)
    else $error("write one did not clear");
  gate_blocks_a: assert property (@(posedge mclk) disable iff (!rstn)
    !wakeOut_reg && !wakeGate_reg |=> !wakeOut_reg) else $error("wake without gate");
  meter_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    $past(cfg.read && hitPm) |-> cfgRdata[14:9] == 6'h0) else $error("meter bits set");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    $past(cfg.read && hitPm) |-> cfgRdata[31:16] == 16'h0 && cfgRdata[7:2] == 6'h0)
    else $error("reserved bits set");
  phy_view_a: assert property (@(posedge mclk) disable iff (!rstn)
    $past(cfg.read && hitPhy) |-> cfgRdata[31:8] == 24'h0 && cfgRdata[3])
    else $error("phy view wrong");
  route_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    !route_reg ##1 !route_reg |-> !cableActivityOut) else $error("route off but driven");
  level_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    !softResetN && !wrPmLo |=> $stable(devicePowerLevel)) else $error("level lost");
  eeprom_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    eepromPhy |=> route_reg == $past(eeprom.data[PPMR_BIT_ROUTE]))
    else $error("eeprom not loaded");
  gate_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    !softResetN && gateSticky && !wrPmHi |=> $stable(wakeGate_reg))
    else $error("sticky gate lost");

  // Gated wake source, the only thing allowed to pull the wake pin
  sequence wakeGatedS;
    wakeSync2_reg && wakeGate_reg;
  endsequence
  sequence flagHeldS;
    wakeFlag_reg && !clearFlag;
  endsequence
  wake_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
    wakeGatedS |=> !wakeOutN) else $error("gated wake not driven");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    flagHeldS |=> wakeFlag_reg) else $error("wake flag lost");
  level_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrPmLo |=> devicePowerLevel == $past(cfg.wdata[1:0])) else $error("level not written");
  level_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !wrPmLo |=> $stable(devicePowerLevel)) else $error("level changed unasked");
  gate_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrPmHi && softResetN |=> wakeGate_reg == $past(cfg.wdata[PPMR_BIT_WAKE_GATE]))
    else $error("gate not written");
  gate_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
    !softResetN && !gateSticky |=> !wakeGate_reg) else $error("gate kept");
  route_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !eepromPhy && !wrPhy |=> $stable(route_reg)) else $error("route changed unasked");
  route_read_a: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.read && hitPhy |=> cfgRdata[PPMR_BIT_ROUTE] == $past(route_reg))
    else $error("route read wrong");
endmodule

// ==== verif/ppmr_host_model.sv ====
// Host configuration master and EEPROM loader facing the register bank
`timescale 1ns/100ps
module ppmr_host_model
  import ppmr_pkg::*;
(
  input wire logic mclk,
  output ppmr_cfg_s cfg,
  output ppmr_eeprom_s eeprom,
  input wire logic [31:0] cfgRdata
);
  initial begin
    cfg = '0;
    eeprom = '0;
  end
  // Released wdata shows the inverse so stale data cannot pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk) #1 cfg = '{~w, w, a, be, d};
    @(posedge mclk) #1 cfg = '{1'b0, 1'b0, a, 4'h0, ~d};
    q = cfgRdata;
  endtask
  task automatic load(input logic [7:0] b);
    @(posedge mclk) #1 eeprom = '{1'b1, b};
    @(posedge mclk) #1 eeprom = '{1'b0, ~b};
  endtask
endmodule

// ==== verif/test_ppmr_regs.sv ====
// Self-checking bench for the power management register bank
`timescale 1ns/100ps
module test_ppmr_regs
  import ppmr_pkg::*;
;
  logic mclk, rstn, softRstN, wakeEv, cap, cabIn, wakeOutN, cabOut;
  logic [1:0] lvl;
  logic [31:0] rdat, q;
  ppmr_cfg_s cfg;
  ppmr_eeprom_s eeprom;
  int bad_count, compares;
  ppmr_host_model host (.mclk(mclk), .cfg(cfg), .eeprom(eeprom), .cfgRdata(rdat));
  ppmr_regs DUT (.mclk(mclk), .rstn(rstn), .softResetN(softRstN), .cfg(cfg),
    .cfgRdata(rdat), .eeprom(eeprom), .wakeEvent(wakeEv), .wakeFromUnpoweredCap(cap),
    .cableActivityIn(cabIn), .wakeOutN(wakeOutN), .devicePowerLevel(lvl),
    .cableActivityOut(cabOut));
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.acc(1'b0, a, 4'hf, '0, q);
    chk("rdata", e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    host.acc(1'b1, a, be, d, q);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_write;
    rd(PPMR_OFF_EXTENSION, 32'h0);
    wr(PPMR_OFF_CTRL_STATUS, 4'hf, 32'hffffffff);
    rd(PPMR_OFF_CTRL_STATUS, 32'h00000103);
    for (int i = 0; i < 4; i++) begin
      wr(PPMR_OFF_CTRL_STATUS, 4'h1, i);
      chk("level", i, {30'h0, lvl});
    end
  endtask
  task automatic t_wake;
    wakeEv = 1;
    wait_cyc(4);
    wakeEv = 0;
    chk("wakeN", 0, {31'h0, wakeOutN});
    rd(PPMR_OFF_CTRL_STATUS, 32'h00008103);
    wr(PPMR_OFF_CTRL_STATUS, 4'h2, 32'h00008100);
    chk("wakeN", 1, {31'h0, wakeOutN});
    wr(PPMR_OFF_CTRL_STATUS, 4'h2, 32'h0);
    wakeEv = 1;
    wait_cyc(4);
    wakeEv = 0;
    chk("wakeN", 1, {31'h0, wakeOutN});
    wr(PPMR_OFF_CTRL_STATUS, 4'h2, 32'h0);
    rd(PPMR_OFF_CTRL_STATUS, 32'h00008003);
    wr(PPMR_OFF_CTRL_STATUS, 4'h2, 32'h00008000);
    rd(PPMR_OFF_CTRL_STATUS, 32'h00000003);
  endtask
  task automatic t_soft(input logic c, input logic [31:0] e);
    cap = c;
    wr(PPMR_OFF_CTRL_STATUS, 4'h3, 32'h00000102);
    softRstN = 0;
    wait_cyc(3);
    softRstN = 1;
    rd(PPMR_OFF_CTRL_STATUS, e);
  endtask
  task automatic t_phy;
    rd(PPMR_OFF_PHY_CTRL, 32'h8);
    host.load(8'h88);
    rd(PPMR_OFF_PHY_CTRL, 32'h88);
    cabIn = 1;
    wait_cyc(4);
    chk("cableOut", 1, {31'h0, cabOut});
    wr(PPMR_OFF_PHY_CTRL, 4'h1, 32'h0);
    wait_cyc(2);
    chk("cableOut", 0, {31'h0, cabOut});
    wr(PPMR_OFF_PHY_CTRL, 4'hf, 32'hffffffff);
    rd(PPMR_OFF_PHY_CTRL, 32'h88);
  endtask
  task automatic t_hard;
    rstn = 0;
    wait_cyc(3);
    rstn = 1;
    chk("wakeN", 1, {31'h0, wakeOutN});
    chk("level", 0, {30'h0, lvl});
    chk("cableOut", 0, {31'h0, cabOut});
    rd(PPMR_OFF_CTRL_STATUS, 32'h0);
    rd(PPMR_OFF_PHY_CTRL, 32'h8);
  endtask
  task report_and_stop;
    $display("Compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rstn, softRstN, wakeEv, cap, cabIn} = 5'b01010;
    wait_cyc(6);
    rstn = 1;
    t_write();
    t_wake();
    t_soft(1'b1, 32'h00000102);
    t_soft(1'b0, 32'h00000002);
    t_phy();
    t_hard();
    report_and_stop();
  end
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule
